// *** core/nfc_regs.svh ***
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH

// Bus timing, host clock 10 MHz
`define NFC_CLK_NS 100
`define NFC_RD_CYCLE_NS 50
`define NFC_RD_CYCLE_CYC ((`NFC_RD_CYCLE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
// Strobe low and high phase length in clocks
`define NFC_PHASE_CYC 1
// Busy-wait timeout: 2 ms erase typical, allowed tenfold
`define NFC_BUSY_TO_US 20000
`define NFC_BUSY_TO_CYC (`NFC_BUSY_TO_US * 1000 / `NFC_CLK_NS)
// Address cycles
`define NFC_ADDR_FULL 2'd3
`define NFC_ADDR_ROW 2'd2
`define NFC_PAGE_BYTES 528

`endif

// *** core/nfc_pkg.sv ***
package nfc_pkg;

  typedef enum logic [1:0] {
    NFC_OP_CMD,
    NFC_OP_ADDR,
    NFC_OP_WDATA,
    NFC_OP_RDATA
  } nfc_op_e;

  // One host request
  typedef struct packed {
    nfc_op_e op;
    logic [7:0] data;
    logic [1:0] naddr;
    logic wait_busy;
  } nfc_req_s;

  // Pins driven toward the flash
  typedef struct packed {
    logic ce_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_guard_n;
  } nfc_pins_s;

endpackage

// *** core/nfc_host.sv ***
`timescale 1ns/1ps
`include "nfc_regs.svh"
// Contract
// - Command byte latched with command strobe
// - Address byte latched with address strobe
// - Write guard low blocks program, erase
// - Read strobe cycle at least 50ns
// - Three address bytes: column, row low, high
// - Erase sends only two row bytes
module nfc_host
  import nfc_pkg::*;
#(
  parameter int BUSY_TO_CYC = `NFC_BUSY_TO_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire nfc_req_s req,
  input wire logic [23:0] req_addr,
  input wire logic guard_en,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic busy_timeout,
  output logic dev_ready,
  output nfc_pins_s pins,
  output logic [7:0] data_bus_pins_o,
  output logic data_bus_pins_oe,
  input wire logic [7:0] data_bus_pins_i,
  input wire logic ready_busy_n
);

  typedef enum logic [2:0] {
    NFC_S_IDLE,
    NFC_S_LOW,
    NFC_S_HIGH,
    NFC_S_BUSY,
    NFC_S_STALL
  } nfc_state_e;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] din_s1_r, din_s2_r;
  logic rb_s1_r, rb_s2_r;
  always_ff @(posedge clock) begin
    din_s1_r <= data_bus_pins_i;
    din_s2_r <= din_s1_r;
    rb_s1_r <= ready_busy_n;
    rb_s2_r <= rb_s1_r;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  nfc_state_e state_r, state_nxt;
  nfc_req_s cur_r;
  logic [23:0] addr_r;
  logic [1:0] acnt_r;
  logic [1:0] phase_r;
  logic [$clog2(BUSY_TO_CYC+1)-1:0] to_cnt_r;
  nfc_pins_s pins_r;
  logic [7:0] dout_r;
  logic oe_r, to_r, rdy_r;

  // Two-entry read buffer
  logic [7:0] buf_mem_r [2];
  logic [1:0] buf_cnt_r;
  logic buf_wp_r, buf_rp_r;
  logic rd_p1_r, rd_p2_r;
  logic req_ready_r, rsp_valid_r;
  logic [7:0] rsp_data_r;
  // Bytes still in the pin synchroniser hold a slot, so a read is only
  // launched when its byte is sure to find room
  wire [1:0] buf_used = buf_cnt_r + {1'b0, rd_p1_r} + {1'b0, rd_p2_r};
  wire buf_full = (buf_used == 2'd2);
  wire buf_push;
  wire buf_pop = rsp_valid_r && rsp_ready;

  wire take = (state_r == NFC_S_IDLE) && req_valid;
  wire is_rd = (cur_r.op == NFC_OP_RDATA);
  wire is_addr = (cur_r.op == NFC_OP_ADDR);
  wire phase_done = (phase_r == 2'(`NFC_PHASE_CYC - 1));
  wire last_addr = !is_addr || (acnt_r == cur_r.naddr - 2'd1);
  wire rb_ready = rb_s2_r;
  wire to_hit = (to_cnt_r == ($bits(to_cnt_r))'(BUSY_TO_CYC - 1));
  // Ready/busy falls only a few clocks after the last strobe; the
  // synchronised level is ignored until the phase count has settled
  wire busy_settled = (phase_r == 2'd3);
  wire phase_run = (state_r == NFC_S_BUSY) ? !busy_settled : !phase_done;
  // A read byte reaches din_s2_r two clocks after the strobe's low phase
  wire rd_launch = (state_r == NFC_S_LOW) && phase_done && is_rd;
  assign buf_push = rd_p2_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      NFC_S_IDLE: begin
        // A full buffer keeps the strobe high: a pulse would advance the column
        if (req_valid && req.op == NFC_OP_RDATA && buf_full) state_nxt = NFC_S_STALL;
        else if (req_valid) state_nxt = NFC_S_LOW;
      end
      NFC_S_LOW: if (phase_done) state_nxt = NFC_S_HIGH;
      NFC_S_STALL: if (!buf_full) state_nxt = NFC_S_LOW;
      NFC_S_HIGH: begin
        if (phase_done) begin
          if (!last_addr) state_nxt = NFC_S_LOW;
          else if (cur_r.wait_busy) state_nxt = NFC_S_BUSY;
          else state_nxt = NFC_S_IDLE;
        end
      end
      NFC_S_BUSY: if ((rb_ready && busy_settled) || to_hit) state_nxt = NFC_S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= NFC_S_IDLE;
      cur_r <= '0;
      addr_r <= '0;
      acnt_r <= '0;
      phase_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        cur_r <= req;
        addr_r <= req_addr;
        acnt_r <= '0;
      end else if (state_r == NFC_S_HIGH && phase_done && !last_addr) begin
        acnt_r <= acnt_r + 2'd1;
      end
      // Phase restarts at every state change; in BUSY it stops at 3
      if (state_nxt != state_r) phase_r <= '0;
      else if (phase_run) phase_r <= phase_r + 2'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || state_r != NFC_S_BUSY) to_cnt_r <= '0;
    else to_cnt_r <= to_cnt_r + 1'b1;
  end

  // ---------------------------------------------------------------
  // Pin drive, all registered
  // ---------------------------------------------------------------
  wire low_nxt = (state_nxt == NFC_S_LOW);
  wire act_nxt = low_nxt || (state_nxt == NFC_S_HIGH) || (state_nxt == NFC_S_STALL);
  wire [1:0] acnt_nxt = (state_r == NFC_S_IDLE) ? 2'd0 :
    ((state_r == NFC_S_HIGH && phase_done && !last_addr) ? acnt_r + 2'd1 : acnt_r);
  wire nfc_op_e op_nxt = take ? req.op : cur_r.op;
  wire [7:0] wbyte_nxt = take ? req.data : cur_r.data;
  // Byte order per cycle: column first, then row low, row high
  wire [7:0] abyte_nxt = take ?
    req_addr[8*((req.naddr == `NFC_ADDR_ROW) ? 2'd1 : 2'd0) +: 8] :
    addr_r[8*((cur_r.naddr == `NFC_ADDR_ROW) ? acnt_nxt + 2'd1 : acnt_nxt) +: 8];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pins_r <= '{ce_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                  write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_guard_n: 1'b0};
      dout_r <= '0;
      oe_r <= 1'b0;
      to_r <= 1'b0;
      rdy_r <= 1'b0;
      req_ready_r <= 1'b1;
    end else begin
      req_ready_r <= (state_nxt == NFC_S_IDLE);
      // Chip stays selected through busy so the operation is not cut
      pins_r.ce_n <= !(act_nxt || state_nxt == NFC_S_BUSY);
      pins_r.cmd_latch <= act_nxt && op_nxt == NFC_OP_CMD;
      pins_r.addr_latch <= act_nxt && op_nxt == NFC_OP_ADDR;
      pins_r.write_strobe_n <= !(low_nxt && op_nxt != NFC_OP_RDATA);
      pins_r.read_strobe_n <= !(low_nxt && op_nxt == NFC_OP_RDATA);
      pins_r.write_guard_n <= guard_en;
      // Drive the bus only for written bytes; the device drives on reads
      oe_r <= act_nxt && op_nxt != NFC_OP_RDATA;
      dout_r <= (op_nxt == NFC_OP_ADDR) ? abyte_nxt : wbyte_nxt;
      to_r <= (state_r == NFC_S_BUSY) && to_hit;
      rdy_r <= rb_ready && (state_nxt == NFC_S_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Read buffer: a stalled consumer pauses the read strobe
  // ---------------------------------------------------------------
  wire [1:0] buf_cnt_nxt = buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
  wire buf_rp_nxt = buf_pop ? !buf_rp_r : buf_rp_r;
  // Head of the queue next cycle: the arriving byte if it lands there
  wire [7:0] head_nxt = (buf_push && buf_wp_r == buf_rp_nxt) ?
    din_s2_r : buf_mem_r[buf_rp_nxt];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      buf_cnt_r <= '0;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      rd_p1_r <= 1'b0;
      rd_p2_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
    end else begin
      buf_cnt_r <= buf_cnt_nxt;
      buf_rp_r <= buf_rp_nxt;
      if (buf_push) buf_wp_r <= !buf_wp_r;
      rd_p1_r <= rd_launch;
      rd_p2_r <= rd_p1_r;
      rsp_valid_r <= (buf_cnt_nxt != 2'd0);
      rsp_data_r <= head_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (buf_push) buf_mem_r[buf_wp_r] <= din_s2_r;
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign req_ready = req_ready_r;
  assign pins = pins_r;
  assign data_bus_pins_o = dout_r;
  assign data_bus_pins_oe = oe_r;
  assign busy_timeout = to_r;
  assign dev_ready = rdy_r;

endmodule

// *** dv/nfc_host_properties.sv ***
`timescale 1ns/1ps
// ----
// Pin protocol checks
// ----
module nfc_host_properties
  import nfc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire nfc_req_s req,
  input wire logic [23:0] req_addr,
  input wire logic guard_en,
  input wire logic busy_timeout,
  input wire nfc_pins_s pins,
  input wire logic [7:0] data_bus_pins_o,
  input wire logic data_bus_pins_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [23:0] addr_q;
  logic take;
  assign take = req_valid && req_ready && req.op == NFC_OP_ADDR;
  always_ff @(posedge clock) addr_q <= req_addr;
  a_latch_excl: assert property (!(pins.cmd_latch && pins.addr_latch))
    else $error("latch overlap");
  a_cmd_rise: assert property ($rose(pins.write_strobe_n) && pins.cmd_latch |->
    !pins.ce_n && data_bus_pins_oe) else $error("command edge bad");
  a_addr_rise: assert property ($rose(pins.write_strobe_n) && pins.addr_latch |->
    !pins.ce_n && data_bus_pins_oe) else $error("address edge bad");
  a_data_hold: assert property (!pins.write_strobe_n |=> $stable(data_bus_pins_o))
    else $error("byte moved at rise");
  a_read_pulse: assert property ($fell(pins.read_strobe_n) |=> pins.read_strobe_n [*2])
    else $error("read cycle short");
  a_col_first: assert property (take && req.naddr == 2'h3 |=>
    pins.addr_latch && data_bus_pins_o == addr_q[7:0]) else $error("column not first");
  a_row_first: assert property (take && req.naddr == 2'h2 |=>
    pins.addr_latch && data_bus_pins_o == addr_q[15:8]) else $error("row not first");
  a_guard_copy: assert property ($past(resetn) |-> pins.write_guard_n == $past(guard_en))
    else $error("guard not copied");
  c_read: cover property ($fell(pins.read_strobe_n));
  c_erase: cover property (take && req.naddr == 2'h2);
  c_timeout: cover property (busy_timeout);
endmodule
bind nfc_host nfc_host_properties nfc_host_properties_inst(.clock(clock), .resetn(resetn),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_addr(req_addr),
  .guard_en(guard_en), .busy_timeout(busy_timeout), .pins(pins),
  .data_bus_pins_o(data_bus_pins_o), .data_bus_pins_oe(data_bus_pins_oe));

// *** dv/nfc_dev_model.sv ***
`timescale 1ns/1ps
// ----
// Flash device model
// ----
module nfc_dev_model
  import nfc_pkg::*;
(
  input wire nfc_pins_s pins,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out = 8'hA5,
  output logic ready_busy_n = 1'h1
);
  logic [7:0] col_r = 8'h00, cmd_r = 8'h00, wd_r = 8'h00;
  logic [15:0] row_r = 16'h0000;
  logic [2:0] n_r = 3'h0, i;
  int lat;
  event go;
  always @(posedge pins.write_strobe_n) if (!pins.ce_n) begin
    i = n_r + {2'h0, cmd_r == 8'h60};
    if (pins.cmd_latch) begin
      cmd_r = bus_in;
      n_r = 3'h0;
      lat = bus_in == 8'h10 ? 2000 : 8000;
      if (pins.write_guard_n && (bus_in == 8'h10 || bus_in == 8'hD0)) ->go;
    end else if (pins.addr_latch) begin
      if (i == 3'h0) col_r = bus_in;
      if (i == 3'h1) row_r[7:0] = bus_in;
      if (i == 3'h2) row_r[15:8] = bus_in;
      if (i == 3'h2 && cmd_r == 8'h00) lat = 500;
      if (i == 3'h2 && cmd_r == 8'h00) ->go;
      if (n_r != 3'h3) n_r++;
    end else wd_r = bus_in;
  end
  // Busy runs on its own; deselect does not cut it short
  always @(go) begin
    ready_busy_n = 1'h0;
    #(lat) ready_busy_n = 1'h1;
  end
  always @(negedge pins.read_strobe_n) if (!pins.ce_n) begin
    bus_out = col_r ^ 8'h5A;
    col_r++;
    #250 bus_out = ~bus_out;
  end
endmodule

// *** dv/nfc_host_bench.sv ***
`timescale 1ns/1ps
// ----
// Host bench
// ----
module nfc_host_bench;
  import nfc_pkg::*;
  logic clock = 1'h0, resetn = 1'h0, req_valid = 1'h0, rsp_ready = 1'h0, guard_en = 1'h1;
  logic stall = 1'h0, req_ready, rsp_valid, busy_timeout, dev_ready, oe, rbn;
  logic [7:0] rsp_data, dout, mout, col, q[$];
  logic [15:0] lfsr = 16'hE9FF, row;
  logic [23:0] req_addr = 24'h000000;
  nfc_req_s req = '0;
  nfc_pins_s pins;
  int error_cnt = 0, check_count = 0, to_cnt = 0;
  always #50 clock = ~clock;
  nfc_host #(.BUSY_TO_CYC(50)) nfc_host_inst(.clock(clock), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_addr(req_addr),
    .guard_en(guard_en), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .busy_timeout(busy_timeout), .dev_ready(dev_ready), .pins(pins), .data_bus_pins_o(dout),
    .data_bus_pins_oe(oe), .data_bus_pins_i(oe ? dout : mout), .ready_busy_n(rbn));
  nfc_dev_model nfc_dev_model_inst(.pins(pins), .bus_in(dout), .bus_out(mout),
    .ready_busy_n(rbn));
  function automatic logic [7:0] rd_exp(logic [7:0] c, int k);
    return (c + 8'(k)) ^ 8'h5A;
  endfunction
  always @(posedge clock) begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rsp_ready <= !stall && lfsr[3];
    if (rsp_valid === 1'h1 && rsp_ready === 1'h1) q.push_back(rsp_data);
    if (busy_timeout === 1'h1) to_cnt <= to_cnt + 1;
  end
  task automatic check(logic [23:0] seen, logic [23:0] exp, string what);
    check_count++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("MISMATCH %s expected %h seen %h", what, exp, seen);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_on(int n);
    int i;
    i = 0;
    do begin @(negedge clock); i++; end while ((n ? q.size() < n : !req_ready) && i < 300);
    if (i >= 300) error_cnt++;
    if (i >= 300) give_verdict();
  endtask
  task automatic send(nfc_op_e op, logic [7:0] d, logic [1:0] n = 2'h3, logic wb = 1'h0);
    wait_on(0);
    @(posedge clock);
    req <= '{op, d, n, wb};
    req_valid <= 1'h1;
    @(posedge clock);
    req_valid <= 1'h0;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    for (int t = 0; t < 2; t++) begin
      col = t ? lfsr[7:0] : 8'hFE;
      row = t ? lfsr : 16'hFFFF;
      @(posedge clock);
      req_addr <= {row, col};
      send(NFC_OP_CMD, 8'h00);
      send(NFC_OP_ADDR, 8'h00, 2'h3, 1'h1);
      stall = t[0];
      fork begin repeat (40) @(negedge clock); stall = 1'h0; end join_none
      repeat (4) send(NFC_OP_RDATA, 8'h00);
      wait_on(4);
      check(nfc_dev_model_inst.row_r, row, "row");
      for (int k = 0; k < 4; k++) check(q[k], rd_exp(col, k), "read byte");
      q.delete();
      $display("read test %0d done", t);
    end
    send(NFC_OP_CMD, 8'h80);
    send(NFC_OP_ADDR, 8'h00);
    repeat (3) send(NFC_OP_WDATA, lfsr[7:0]);
    col = req.data;
    send(NFC_OP_CMD, 8'h10, 2'h3, 1'h1);
    wait_on(0);
    repeat (2) @(negedge clock);
    check(nfc_dev_model_inst.wd_r, col, "data byte");
    check({to_cnt[7:0], dev_ready}, 9'h001, "program wait");
    $display("program test done");
    for (int g = 0; g < 2; g++) begin
      row = lfsr;
      @(posedge clock);
      guard_en <= g[0];
      req_addr <= {row, 8'h77};
      send(NFC_OP_CMD, 8'h60);
      send(NFC_OP_ADDR, 8'h00, 2'h2);
      send(NFC_OP_CMD, 8'hD0, 2'h3, 1'h1);
      wait_on(0);
      repeat (2) @(negedge clock);
      check(nfc_dev_model_inst.row_r, row, "erase row");
      check(to_cnt, g, "busy timeouts");
      $display("erase test %0d done", g);
    end
    give_verdict();
  end
endmodule
